// File: rtl/kbd_host_consts.svh
// offsets, field positions, reset values and timing counts of the host mailbox
`ifndef KBD_HOST_CONSTS_SVH
`define KBD_HOST_CONSTS_SVH
`define KBD_ADDR_DATA 8'h60
`define KBD_ADDR_CMD 8'h64
`define KBD_ADDR_BIT_CD 2
`define KBD_ST_OBF 0
`define KBD_ST_IBF 1
`define KBD_ST_CD 3
`define KBD_ST_RESET 8'h00
`define KBD_ST_CPU_MASK 8'hf4
`define KBD_CLK_NS 10
`define KBD_PP_HIGH_NS 500
`define KBD_PP_HIGH_CYC ((`KBD_PP_HIGH_NS + `KBD_CLK_NS - 1) / `KBD_CLK_NS)
`define KBD_ROM_BYTES 2048
`define KBD_RAM_BYTES 256
`endif

// File: rtl/kbd_host_pkg.sv
// types shared by the host mailbox block
package kbd_host_pkg;
  typedef enum logic [1:0] {
    PWR_RUN = 2'b00,
    PWR_SOFT = 2'b01,
    PWR_HARD = 2'b10
  } pwr_state_e;

  typedef enum logic [1:0] {
    WAKE_NONE = 2'b00,
    WAKE_IRQ = 2'b01,
    WAKE_NEXT = 2'b10,
    WAKE_RESET = 2'b11
  } wake_kind_e;

  typedef struct packed {
    logic [7:0] in_buf;
    logic [7:0] out_buf;
    logic [7:0] status;
    logic flags_en;
    logic [7:0] port_ff;
    logic [2:0] legacy_q;
    logic [2:0][5:0] pp_cnt;
    logic [1:0][1:0] sense_s1;
    logic [1:0][1:0] sense_s2;
    pwr_state_e pwr;
    wake_kind_e wake;
    logic wake_pulse;
    logic [7:0] host_rdata;
  } kbd_state_s;
endpackage : kbd_host_pkg

// File: rtl/kbd_ctrl_host_interface.sv
// host mailbox, port pins and power-down control of the keyboard controller
`timescale 1ns/1ns
`include "kbd_host_consts.svh"

module kbd_ctrl_host_interface
  import kbd_host_pkg::*;
#(
  // core memory sizes, held here so the core sizes its arrays from them
  parameter int ROM_BYTES = `KBD_ROM_BYTES,
  parameter int RAM_BYTES = `KBD_RAM_BYTES
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // host i/o cycles, one cycle strobes
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [7:0] host_addr_i,
  input wire logic [7:0] host_wdata_i,
  output logic [7:0] host_rdata_o,
  output logic kbd_host_irq_o,
  output logic aux_host_irq_o,
  // internal controller cpu side
  input wire logic cpu_out_wr_i,
  input wire logic [7:0] cpu_out_data_i,
  input wire logic cpu_in_rd_i,
  output logic [7:0] cpu_in_data_o,
  output logic [7:0] cpu_status_o,
  input wire logic cpu_status_wr_i,
  input wire logic [7:0] cpu_status_data_i,
  input wire logic cpu_port_wr_i,
  input wire logic [7:0] cpu_port_data_i,
  input wire logic cpu_en_flags_i,
  input wire logic cpu_ibf_irq_en_i,
  input wire logic cpu_halt_i,
  input wire logic cpu_stop_i,
  output logic ibf_irq_o,
  output logic alu_clk_en_o,
  output logic osc_en_o,
  output logic [1:0] wake_kind_o,
  output logic wake_pulse_o,
  // legacy port pins a/b/c and their mode
  input wire logic legacy_open_drain_i,
  output logic [2:0] legacy_port_o,
  output logic [2:0] legacy_port_oe_o,
  output logic gate_a20_o,
  // keyboard and aux open-drain pins: [0] clock, [1] data
  input wire logic [1:0] kbd_pin_i,
  output logic [1:0] kbd_pin_o,
  output logic [1:0] kbd_pin_oe_o,
  input wire logic [1:0] aux_pin_i,
  output logic [1:0] aux_pin_o,
  output logic [1:0] aux_pin_oe_o,
  output logic kbd_clock_sense_o,
  output logic kbd_data_sense_o,
  output logic aux_clock_sense_o,
  output logic aux_data_sense_o
);
  // port bit positions of the controller output port
  localparam int GA20 = 1;
  localparam int AUX_DAT = 2;
  localparam int AUX_CLK = 3;
  localparam int KBD_HOST_IRQ_B = 4;
  localparam int AIRQ_B = 5;
  localparam int KBD_CLK = 6;
  localparam int KBD_DAT = 7;
  localparam logic [5:0] PP_CYC = 6'(`KBD_PP_HIGH_CYC);
  localparam int LEG_BIT [3] = '{2, 6, 7};

  kbd_state_s st_ff;
  kbd_state_s nxt_st;
  logic host_wr_hit;
  logic host_data_rd;
  logic [1:0] pin_raw;
  logic [7:0] st_obf_view;
  logic [2:0] leg_new;

  assign host_wr_hit = host_wr_i &&
    (host_addr_i == `KBD_ADDR_DATA || host_addr_i == `KBD_ADDR_CMD);
  assign host_data_rd = host_rd_i && host_addr_i == `KBD_ADDR_DATA;

  // open-drain pins: drive low when the port bit is one, else release
  generate
    for (genvar i = 0; i < 2; i++) begin : g_od
      assign kbd_pin_o[i] = 1'b0;
      assign aux_pin_o[i] = 1'b0;
      assign kbd_pin_oe_o[i] = st_ff.port_ff[i == 0 ? KBD_CLK : KBD_DAT];
      assign aux_pin_oe_o[i] = st_ff.port_ff[i == 0 ? AUX_CLK : AUX_DAT];
    end
  endgenerate

  // legacy pins: fixed outputs, no inversion; push-pull or open-drain
  generate
    for (genvar i = 0; i < 3; i++) begin : g_leg
      assign leg_new[i] = st_ff.port_ff[LEG_BIT[i]];
      assign legacy_port_o[i] = st_ff.legacy_q[i];
      assign legacy_port_oe_o[i] = !st_ff.legacy_q[i] ||
        (!legacy_open_drain_i && st_ff.pp_cnt[i] != 6'h00);
    end
  endgenerate

  always_comb begin
    nxt_st = st_ff;
    nxt_st.wake_pulse = 1'b0;
    for (int i = 0; i < 2; i++) begin
      nxt_st.sense_s1[i] = {aux_pin_i[i], kbd_pin_i[i]};
      nxt_st.sense_s2[i] = st_ff.sense_s1[i];
    end
    // host write into the input buffer, address bit 2 picks command/data
    if (host_wr_hit) begin
      nxt_st.in_buf = host_wdata_i;
      nxt_st.status[`KBD_ST_CD] = host_addr_i[`KBD_ADDR_BIT_CD];
    end
    // cpu reads input: clear INPUT_FULL_FLAG; a simultaneous host write wins
    if (cpu_in_rd_i) begin
      nxt_st.status[`KBD_ST_IBF] = 1'b0;
    end
    if (host_wr_hit) begin
      nxt_st.status[`KBD_ST_IBF] = 1'b1;
    end
    // user bits writable only from the cpu; keeps this cycle's flag updates
    if (cpu_status_wr_i) begin
      nxt_st.status = (nxt_st.status & ~`KBD_ST_CPU_MASK) |
        (cpu_status_data_i & `KBD_ST_CPU_MASK);
    end
    // host data read clears OUTPUT_FULL_FLAG only with gating; cpu write set wins
    if (host_data_rd && st_ff.flags_en) begin
      nxt_st.status[`KBD_ST_OBF] = 1'b0;
    end
    if (cpu_out_wr_i) begin
      nxt_st.out_buf = cpu_out_data_i;
      nxt_st.status[`KBD_ST_OBF] = 1'b1;
    end
    // status read is a pure view; data read returns the output byte
    nxt_st.host_rdata = 8'h00;
    if (host_data_rd) begin
      nxt_st.host_rdata = st_ff.out_buf;
    end else if (host_rd_i && host_addr_i == `KBD_ADDR_CMD) begin
      nxt_st.host_rdata = st_ff.status;
    end
    if (cpu_en_flags_i) begin
      nxt_st.flags_en = 1'b1;
    end
    if (cpu_port_wr_i) begin
      nxt_st.port_ff = cpu_port_data_i;
    end
    // a rising port one reloads the active-high window
    for (int i = 0; i < 3; i++) begin
      nxt_st.legacy_q[i] = leg_new[i];
      if (leg_new[i] && !st_ff.legacy_q[i]) begin
        nxt_st.pp_cnt[i] = PP_CYC;
      end else if (st_ff.pp_cnt[i] != 6'h00) begin
        nxt_st.pp_cnt[i] = st_ff.pp_cnt[i] - 6'h01;
      end
    end
    // power-down; only a host write or reset wakes the core
    case (st_ff.pwr)
      PWR_RUN: begin
        if (cpu_stop_i) begin
          nxt_st.pwr = PWR_HARD;
        end else if (cpu_halt_i) begin
          nxt_st.pwr = PWR_SOFT;
        end
      end
      PWR_SOFT, PWR_HARD: begin
        if (host_wr_hit) begin
          nxt_st.pwr = PWR_RUN;
          nxt_st.wake_pulse = 1'b1;
          nxt_st.wake = cpu_ibf_irq_en_i ? WAKE_IRQ : WAKE_NEXT;
        end
      end
      default: begin
        nxt_st.pwr = PWR_RUN;
      end
    endcase
  end

  // reset restarts from program address zero and zeroes the status
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      st_ff <= '0;
      st_ff.status <= `KBD_ST_RESET;
      st_ff.wake <= WAKE_RESET;
      st_ff.wake_pulse <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign st_obf_view = st_ff.status;
  assign host_rdata_o = st_ff.host_rdata;
  // gated mode ties the host irqs to the flags, else to the port bits
  assign kbd_host_irq_o = st_ff.flags_en ?
    (st_ff.port_ff[KBD_HOST_IRQ_B] && st_obf_view[`KBD_ST_OBF]) :
    st_ff.port_ff[KBD_HOST_IRQ_B];
  assign aux_host_irq_o = st_ff.flags_en ?
    (st_ff.port_ff[AIRQ_B] && !st_obf_view[`KBD_ST_IBF]) :
    st_ff.port_ff[AIRQ_B];
  assign gate_a20_o = st_ff.port_ff[GA20];
  assign cpu_in_data_o = st_ff.in_buf;
  assign cpu_status_o = st_ff.status;
  // only input-full raises an internal irq here; timer overflow is core side
  assign ibf_irq_o = st_ff.status[`KBD_ST_IBF];
  assign alu_clk_en_o = st_ff.pwr == PWR_RUN;
  assign osc_en_o = st_ff.pwr != PWR_HARD;
  assign wake_kind_o = st_ff.wake;
  assign wake_pulse_o = st_ff.wake_pulse;
  assign kbd_clock_sense_o = st_ff.sense_s2[0][0];
  assign kbd_data_sense_o = st_ff.sense_s2[1][0];
  assign aux_clock_sense_o = st_ff.sense_s2[0][1];
  assign aux_data_sense_o = st_ff.sense_s2[1][1];
endmodule : kbd_ctrl_host_interface

// File: verif/kbd_host_asserts.sv
// concurrent checks on the host mailbox ports
`timescale 1ns/1ns
module kbd_host_asserts (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // watched ports
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [7:0] host_addr_i,
  input wire logic [7:0] host_rdata_o,
  input wire logic kbd_host_irq_o,
  input wire logic cpu_out_wr_i,
  input wire logic cpu_in_rd_i,
  input wire logic cpu_status_wr_i,
  input wire logic [7:0] cpu_status_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic wd;
  logic wc;
  logic rs;
  assign wd = host_wr_i && host_addr_i == 8'h60;
  assign wc = host_wr_i && host_addr_i == 8'h64;
  assign rs = host_rd_i && host_addr_i == 8'h64;
  chk_data_wr: assert property (
    wd |=> !cpu_status_o[3] && cpu_status_o[1]) else $error("data wr");
  chk_cmd_wr: assert property (
    wc |=> cpu_status_o[3] && cpu_status_o[1]) else $error("cmd wr");
  chk_status_rd: assert property (
    rs |=> host_rdata_o == $past(cpu_status_o)) else $error("status rd");
  chk_status_calm: assert property (
    rs && !host_wr_i && !cpu_out_wr_i && !cpu_in_rd_i && !cpu_status_wr_i |=>
    $stable(cpu_status_o)) else $error("status side effect");
  chk_obf_set: assert property (
    cpu_out_wr_i |=> cpu_status_o[0]) else $error("obf set");
  chk_obf_hold: assert property (
    cpu_status_o[0] && !host_rd_i |=> cpu_status_o[0]) else $error("obf");
  chk_ibf_clear: assert property (
    cpu_in_rd_i && !host_wr_i |=> !cpu_status_o[1]) else $error("ibf");
  chk_irq_reset: assert property (
    $rose(reset_n_i) |-> !kbd_host_irq_o) else $error("irq after reset");
  cover property (wd);
  cover property (rs);
  cover property (cpu_out_wr_i ##[1:20] host_rd_i);
endmodule : kbd_host_asserts

bind kbd_ctrl_host_interface kbd_host_asserts i_chk (
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .host_wr_i(host_wr_i),
  .host_rd_i(host_rd_i), .host_addr_i(host_addr_i),
  .host_rdata_o(host_rdata_o), .kbd_host_irq_o(kbd_host_irq_o),
  .cpu_out_wr_i(cpu_out_wr_i), .cpu_in_rd_i(cpu_in_rd_i),
  .cpu_status_wr_i(cpu_status_wr_i), .cpu_status_o(cpu_status_o));

// File: verif/host_io_model.sv
// host processor model issuing single-byte i/o cycles
`timescale 1ns/1ns
module host_io_model (
  // clock and returned data
  input wire logic ref_clk_i,
  input wire logic [7:0] rdata_i,
  // i/o cycle
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  // released lines show the inverse so stale values never look valid
  task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge ref_clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
    #1;
  endtask : io_wr
  task automatic io_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge ref_clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1 d = rdata_i;
  endtask : io_rd
endmodule : host_io_model

// File: verif/tb_top.sv
// self-checking bench for the host mailbox block
`timescale 1ns/1ns
module tb_top;
  logic clk, rst_n, wr, rd, od, ie, ki, ai, a20, alu, osc, wp, sw, ib;
  logic [7:0] ad, wd, rdt, cd, got, cin, n, cst;
  logic [5:0] cs;
  logic [1:0] wk, wkc, kpe, ape, kpo, apo;
  logic [2:0] lo, loe;
  logic [3:0] sen;
  int failures, num_checks;
  host_io_model host (.ref_clk_i(clk), .rdata_i(rdt), .wr_o(wr),
    .rd_o(rd), .addr_o(ad), .wdata_o(wd));
  kbd_ctrl_host_interface i_dut (.ref_clk_i(clk), .reset_n_i(rst_n),
    .host_wr_i(wr), .host_rd_i(rd), .host_addr_i(ad), .host_wdata_i(wd),
    .host_rdata_o(rdt), .kbd_host_irq_o(ki), .aux_host_irq_o(ai),
    .cpu_out_wr_i(cs[0]), .cpu_out_data_i(cd), .cpu_in_rd_i(cs[1]),
    .cpu_in_data_o(cin), .cpu_status_o(cst), .cpu_status_wr_i(sw),
    .cpu_status_data_i(cd), .cpu_port_wr_i(cs[2]), .cpu_port_data_i(cd),
    .cpu_en_flags_i(cs[3]), .cpu_ibf_irq_en_i(ie), .cpu_halt_i(cs[4]),
    .cpu_stop_i(cs[5]), .ibf_irq_o(ib), .alu_clk_en_o(alu), .osc_en_o(osc),
    .wake_kind_o(wk), .wake_pulse_o(wp), .legacy_open_drain_i(od),
    .legacy_port_o(lo), .legacy_port_oe_o(loe), .gate_a20_o(a20),
    .kbd_pin_i(~kpe), .kbd_pin_o(kpo), .kbd_pin_oe_o(kpe), .aux_pin_i(~ape),
    .aux_pin_o(apo), .aux_pin_oe_o(ape), .kbd_clock_sense_o(sen[3]),
    .kbd_data_sense_o(sen[2]), .aux_clock_sense_o(sen[1]),
    .aux_data_sense_o(sen[0]));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // the wake pulse lasts one cycle except while reset is held, so latch its kind here
  always @(posedge clk) if (wp === 1'b1) wkc <= wk;
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic cpu(input logic [5:0] s, input logic [7:0] d);
    @(posedge clk);
    cs <= s;
    cd <= d;
    @(posedge clk);
    cs <= 6'h00;
    #1;
  endtask : cpu
  task automatic st(input logic [7:0] e);
    host.io_rd(8'h64, got);
    chk(got, e);
  endtask : st
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  task automatic woke(input logic [7:0] e);
    for (n = 0; n < 8'd10 && alu !== 1'b1; n++) @(posedge clk);
    if (n == 8'd10) begin
      failures++;
      close_out();
    end else begin
      @(posedge clk);
      #1 chk({6'h0, wkc}, e);
    end
  endtask : woke
  initial begin
    rst_n = 1'b0;
    cs = 6'h00;
    cd = 8'h00;
    sw = 1'b0;
    od = 1'b0;
    ie = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    st(8'h00);
    chk({6'h0, ki, wkc[0]}, 8'h01);
    cpu(6'h04, 8'h32);
    chk({5'h0, a20, ki, ai}, 8'h07);
    cpu(6'h04, 8'h00);
    chk({5'h0, a20, ki, ai}, 8'h00);
    $display("test port outputs done");
    host.io_wr(8'h60, 8'h3c);
    st(8'h02);
    chk(cin, 8'h3c);
    chk({7'h0, ib}, 8'h01);
    host.io_wr(8'h64, 8'hc3);
    st(8'h0a);
    cpu(6'h02, 8'h00);
    st(8'h08);
    chk({7'h0, ib}, 8'h00);
    cpu(6'h01, 8'ha5);
    st(8'h09);
    host.io_rd(8'h60, got);
    chk(got, 8'ha5);
    st(8'h09);
    @(posedge clk);
    sw <= 1'b1;
    cd <= 8'hff;
    @(posedge clk);
    sw <= 1'b0;
    #1 chk(cst, 8'hfd);
    st(8'hfd);
    $display("test mailbox done");
    cpu(6'h08, 8'h00);
    cpu(6'h04, 8'h30);
    chk({6'h0, ki, ai}, 8'h03);
    host.io_wr(8'h60, 8'h11);
    chk({6'h0, ki, ai}, 8'h02);
    host.io_rd(8'h60, got);
    chk({6'h0, ki, ai}, 8'h00);
    cpu(6'h04, 8'h00);
    cpu(6'h01, 8'h5a);
    chk({6'h0, ki, ai}, 8'h00);
    cpu(6'h04, 8'h10);
    chk({6'h0, ki, ai}, 8'h02);
    $display("test gated flags done");
    cpu(6'h04, 8'hc4);
    // the legacy pins follow the port register one clock later
    @(posedge clk);
    #1 chk({5'h0, lo}, 8'h07);
    n = 8'h00;
    repeat (60) begin
      if (loe === 3'b111) n++;
      @(posedge clk);
      #1;
    end
    chk(n, 8'd50);
    chk({kpo, apo, kpe, ape}, 8'h0e);
    chk({4'h0, sen}, 8'h02);
    @(posedge clk);
    od <= 1'b1;
    cpu(6'h04, 8'h00);
    @(posedge clk);
    #1 chk({2'h0, lo, loe}, 8'h07);
    cpu(6'h04, 8'hc4);
    @(posedge clk);
    #1 chk({5'h0, loe}, 8'h00);
    $display("test pins done");
    @(posedge clk);
    ie <= 1'b1;
    cpu(6'h10, 8'h00);
    chk({7'h0, alu}, 8'h00);
    host.io_wr(8'h64, 8'h01);
    woke(8'h01);
    @(posedge clk);
    ie <= 1'b0;
    cpu(6'h20, 8'h00);
    chk({6'h0, osc, alu}, 8'h00);
    host.io_wr(8'h60, 8'h02);
    woke(8'h02);
    // reset in hard power-down restarts the core and clears the mailbox
    cpu(6'h20, 8'h00);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    woke(8'h03);
    chk({6'h0, ki, osc}, 8'h01);
    st(8'h00);
    $display("test power down done");
    close_out();
  end
endmodule : tb_top
